/* verilog/uart_defines.svh */
// Register indices, field positions, reset values and timing constants.
`ifndef UART_DEFINES_SVH
`define UART_DEFINES_SVH
`define ADDR_STATUS     3'h0
`define ADDR_CTRL_A     3'h1
`define ADDR_CTRL_B     3'h2
`define ADDR_DATA       3'h3
`define ADDR_BAUD       3'h4
`define CA_MODULE_EN    7
`define CA_NINE_BIT     6
`define CA_PARITY_EN    5
`define CA_PARITY_ODD   4
`define CA_TWO_STOP     3
`define CA_SEND_BREAK   2
`define CA_RX_NINTH     1
`define CA_TX_NINTH     0
`define CB_TX_ON        7
`define CB_RX_ON        6
`define CB_HIGH_SPEED   5
`define CB_ADDR_DETECT  4
`define CB_WAKE_EN      3
`define CB_RX_IRQ_EN    2
`define CB_IDLE_IRQ_EN  1
`define CB_EMPTY_IRQ_EN 0
`define CTRL_RESET      8'h00
`define BAUD_RESET      8'h00
`define SLOW_EXTRA      2'h3
`define SUB_LAST        4'hF
`define SAMPLE_A        4'h7
`define SAMPLE_B        4'h8
`define SAMPLE_C        4'h9
`define BITS_SHORT      4'h8
`define BITS_LONG       4'h9
`define FRAME_MAX       4'hD
`endif

/* verilog/uart_pkg.sv */
// Types shared by the serial transceiver and its testbench.
package uart_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic       ninth;
      logic [7:0] data;
   } rx_word_t;
   typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_t;
endpackage

/* verilog/async_serial_transceiver.sv */
// Full-duplex asynchronous serial transceiver with its receive queue.
`include "uart_defines.svh"

module rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 2
) (
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic             flush_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   if (DEPTH < 1 || WIDTH < 1) begin : g_bad_size
      $error("rx_fifo needs positive width and depth");
   end

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
   assign out_valid_out = (count_reg != '0);
   assign out_data_out  = mem_reg[rd_ptr_reg];
   assign push = in_valid_in && in_ready_out;
   assign pop  = out_ready_in && out_valid_out;

   always_ff @(posedge clk_in) begin
      if (push)
         mem_reg[wr_ptr_reg] <= in_data_in;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || flush_in) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg  <= '0;
      end else begin
         if (push)
            wr_ptr_reg <= bump(wr_ptr_reg);
         if (pop)
            rd_ptr_reg <= bump(rd_ptr_reg);
         if (push && !pop)
            count_reg <= count_reg + 1'b1;
         else if (pop && !push)
            count_reg <= count_reg - 1'b1;
      end
   end
endmodule

module async_serial_transceiver
   import uart_pkg::*;
#(
   parameter int RX_DEPTH = 2
) (
   input  wire logic     clk_in,
   input  wire reg_req_t reg_req_in,
   input  wire logic     rst_in,
   output logic [7:0]    reg_rdata_out,
   input  wire logic     rx_pin_in,
   input  wire logic     lcd_active_in,
   output logic          tx_pin_out,
   output logic          tx_pin_oe_out,
   output logic          rx_pin_owned_out,
   output logic          rx_pullup_off_out,
   output logic          irq_tx_empty_out,
   output logic          irq_tx_idle_out,
   output logic          irq_receive_out,
   output logic          irq_overrun_out,
   output logic          irq_address_out,
   output logic          irq_wake_out
);
   if (RX_DEPTH < 1) begin : g_bad_depth
      $error("receive queue depth must be at least one");
   end

   logic [7:0]  ctrl_a_reg;
   logic [7:0]  ctrl_b_reg;
   logic [7:0]  baud_reg;
   logic [7:0]  tx_data_reg;
   logic        transmit_register_empty_reg;
   logic        transmitter_idle_flag_reg;
   logic        parity_error_flag_reg;
   logic        nf_reg;
   logic        framing_error_flag_reg;
   logic        overrun_flag_reg;
   logic        status_seen_reg;
   logic [9:0]  baud_cnt_reg;
   logic        tick_reg;
   logic [2:0]  rx_sync_reg;
   logic        rx_filt_reg;
   tx_state_t   tx_state_reg;
   logic [12:0] tx_shift_reg;
   logic [3:0]  tx_left_reg;
   logic [3:0]  tx_sub_reg;
   rx_state_t   rx_state_reg;
   logic [3:0]  rx_sub_reg;
   logic [3:0]  rx_idx_reg;
   logic [2:0]  rx_samp_reg;
   logic [8:0]  rx_shift_reg;
   logic        rx_par_reg;
   logic        rx_noise_reg;
   logic        rx_done_reg;
   logic        rx_parity_error_flag_reg;
   logic        rx_framing_error_flag_reg;

   logic     mod_en;
   logic     tx_on;
   logic     rx_on;
   logic     nine;
   logic     par_en;
   logic [3:0] data_bits;
   logic     wr_data;
   logic     rd_data;
   logic     rd_status;
   logic     err_clear;
   logic     tx_load;
   logic     fifo_in_ready;
   logic     fifo_valid;
   rx_word_t fifo_head;
   rx_word_t rx_word;
   logic     head_msb;
   logic     maj;
   logic     pins_free;

   assign mod_en    = ctrl_a_reg[`CA_MODULE_EN];
   assign tx_on     = mod_en && ctrl_b_reg[`CB_TX_ON];
   assign rx_on     = mod_en && ctrl_b_reg[`CB_RX_ON];
   assign nine      = ctrl_a_reg[`CA_NINE_BIT];
   assign par_en    = ctrl_a_reg[`CA_PARITY_EN];
   assign data_bits = nine ? `BITS_LONG : `BITS_SHORT;
   assign pins_free = !lcd_active_in;
   assign wr_data   = reg_req_in.wr && reg_req_in.addr == `ADDR_DATA;
   assign rd_data   = reg_req_in.rd && reg_req_in.addr == `ADDR_DATA;
   assign rd_status = reg_req_in.rd && reg_req_in.addr == `ADDR_STATUS;
   assign err_clear = status_seen_reg && (wr_data || rd_data);
   assign head_msb  = nine ? fifo_head.ninth : fifo_head.data[7];
   assign maj = (rx_samp_reg[0] & rx_samp_reg[1]) |
                (rx_samp_reg[1] & rx_samp_reg[2]) |
                (rx_samp_reg[0] & rx_samp_reg[2]);

   // Builds a frame right-aligned for LSB-first shifting; unused high
   // positions are ones so that stop bits need no separate handling.
   function automatic logic [12:0] build_frame(
      input logic [7:0] d, input logic d9, input logic brk);
      logic [12:0] f;
      logic [3:0]  pos;
      logic        p;
      f   = '1;
      pos = `BITS_SHORT + 4'h1;
      p   = ^d ^ (nine & d9) ^ ctrl_a_reg[`CA_PARITY_ODD];
      f[0]   = 1'b0;
      f[8:1] = d;
      if (nine) begin
         f[pos] = d9;
         pos    = pos + 4'h1;
      end
      if (par_en)
         f[pos] = p;
      if (brk)
         f = '0;
      build_frame = f;
   endfunction

   function automatic logic [3:0] frame_len();
      frame_len = data_bits + 4'h2 + {3'h0, par_en} +
                  {3'h0, ctrl_a_reg[`CA_TWO_STOP]};
   endfunction

   // Register writes; the ninth receive bit is stored with the rest but never used or read back.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ctrl_a_reg <= `CTRL_RESET;
         ctrl_b_reg <= `CTRL_RESET;
         baud_reg   <= `BAUD_RESET;
      end else begin
         if (reg_req_in.wr && reg_req_in.addr == `ADDR_CTRL_A)
            ctrl_a_reg <= reg_req_in.wdata;
         if (reg_req_in.wr && reg_req_in.addr == `ADDR_CTRL_B)
            ctrl_b_reg <= reg_req_in.wdata;
         if (reg_req_in.wr && reg_req_in.addr == `ADDR_BAUD)
            baud_reg <= reg_req_in.wdata;
         if (!mod_en) begin
            ctrl_a_reg[`CA_SEND_BREAK] <= 1'b0;
            ctrl_b_reg[`CB_TX_ON]      <= 1'b0;
            ctrl_b_reg[`CB_RX_ON]      <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in)
         tx_data_reg <= '0;
      else if (wr_data)
         tx_data_reg <= reg_req_in.wdata;
   end

   // Readback: shift registers never appear here. An empty queue reads
   // as zero, since its storage is never reset and would leak unknowns.
   always_ff @(posedge clk_in) begin
      if (rst_in)
         reg_rdata_out <= '0;
      else if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            `ADDR_STATUS: reg_rdata_out <= {parity_error_flag_reg, nf_reg, framing_error_flag_reg,
               overrun_flag_reg, rx_state_reg == RX_IDLE, fifo_valid,
               transmitter_idle_flag_reg, transmit_register_empty_reg};
            `ADDR_CTRL_A: reg_rdata_out <= {ctrl_a_reg[7:2],
               fifo_valid && fifo_head.ninth, 1'b0};
            `ADDR_CTRL_B: reg_rdata_out <= ctrl_b_reg;
            `ADDR_DATA:   reg_rdata_out <= fifo_valid ? fifo_head.data
                                           : 8'h00;
            `ADDR_BAUD:   reg_rdata_out <= baud_reg;
            default:      reg_rdata_out <= '0;
         endcase
      end
   end

   // Baud generator: one tick per sixteenth of a bit. Slow mode
   // stretches each tick by four so the 8-bit divisor reaches low rates.
   always_ff @(posedge clk_in) begin
      if (rst_in || !mod_en) begin
         baud_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else if (baud_cnt_reg == '0) begin
         baud_cnt_reg <= ctrl_b_reg[`CB_HIGH_SPEED] ? {2'h0, baud_reg}
                         : {baud_reg, `SLOW_EXTRA};
         tick_reg     <= 1'b1;
      end else begin
         baud_cnt_reg <= baud_cnt_reg - 1'b1;
         tick_reg     <= 1'b0;
      end
   end

   assign tx_load = tx_state_reg == TX_IDLE && tx_on && pins_free &&
                    (!transmit_register_empty_reg || ctrl_a_reg[`CA_SEND_BREAK]);

   // Transmitter.
   always_ff @(posedge clk_in) begin
      if (rst_in || !tx_on) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= '1;
         tx_left_reg  <= '0;
         tx_sub_reg   <= '0;
      end else begin
         unique case (tx_state_reg)
            TX_IDLE: if (tx_load) begin
               tx_shift_reg <= build_frame(tx_data_reg,
                  ctrl_a_reg[`CA_TX_NINTH], !transmit_register_empty_reg ? 1'b0
                  : ctrl_a_reg[`CA_SEND_BREAK]);
               tx_left_reg  <= frame_len();
               tx_sub_reg   <= '0;
               tx_state_reg <= TX_SHIFT;
            end
            TX_SHIFT: if (tick_reg) begin
               tx_sub_reg <= tx_sub_reg + 1'b1;
               if (tx_sub_reg == `SUB_LAST) begin
                  tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
                  tx_left_reg  <= tx_left_reg - 1'b1;
                  if (tx_left_reg == 4'h1)
                     tx_state_reg <= TX_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !tx_on)
         tx_pin_out <= 1'b1;
      else if (tx_load && !transmit_register_empty_reg)
         tx_pin_out <= 1'b0;
      else if (tx_load)
         tx_pin_out <= 1'b0;
      else if (tx_state_reg == TX_SHIFT && tick_reg &&
               tx_sub_reg == `SUB_LAST)
         tx_pin_out <= (tx_left_reg == 4'h1) ? 1'b1
                       : tx_shift_reg[1];
   end

   // Holding register empty and idle flags. A load sets empty even in
   // the cycle of a data write, so software must wait for the empty
   // flag before it writes the next byte.
   always_ff @(posedge clk_in) begin
      if (rst_in || !mod_en)
         transmit_register_empty_reg <= 1'b1;
      else if (tx_load && !transmit_register_empty_reg)
         transmit_register_empty_reg <= 1'b1;
      else if (wr_data)
         transmit_register_empty_reg <= 1'b0;
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !mod_en)
         transmitter_idle_flag_reg <= 1'b1;
      else
         transmitter_idle_flag_reg <= transmit_register_empty_reg && tx_state_reg == TX_IDLE &&
                      !tx_load && !wr_data;
   end

   // Receive pin: three stages, a change counts once the last two agree.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         rx_sync_reg <= '1;
         rx_filt_reg <= 1'b1;
      end else begin
         rx_sync_reg <= {rx_sync_reg[1:0], rx_pin_in};
         if (rx_sync_reg[2] == rx_sync_reg[1])
            rx_filt_reg <= rx_sync_reg[2] || !rx_on || !pins_free;
      end
   end

   // Receiver: sixteen ticks per bit, samples 7..9 voted.
   always_ff @(posedge clk_in) begin
      if (rst_in || !rx_on) begin
         rx_state_reg <= RX_IDLE;
         rx_sub_reg   <= '0;
         rx_idx_reg   <= '0;
         rx_samp_reg  <= '0;
         rx_shift_reg <= '0;
         rx_par_reg   <= 1'b0;
         rx_noise_reg <= 1'b0;
         rx_done_reg  <= 1'b0;
         rx_parity_error_flag_reg  <= 1'b0;
         rx_framing_error_flag_reg  <= 1'b0;
      end else begin
         rx_done_reg <= 1'b0;
         if (tick_reg) begin
            rx_sub_reg <= rx_sub_reg + 1'b1;
            if (rx_sub_reg == `SAMPLE_A || rx_sub_reg == `SAMPLE_B ||
                rx_sub_reg == `SAMPLE_C)
               rx_samp_reg <= {rx_samp_reg[1:0], rx_filt_reg};
         end
         unique case (rx_state_reg)
            RX_IDLE: if (tick_reg && !rx_filt_reg) begin
               rx_state_reg <= RX_START;
               rx_sub_reg   <= '0;
               rx_idx_reg   <= '0;
               rx_noise_reg <= 1'b0;
               rx_par_reg   <= ctrl_a_reg[`CA_PARITY_ODD];
            end
            RX_START: if (tick_reg && rx_sub_reg == `SUB_LAST) begin
               rx_noise_reg <= !(&rx_samp_reg) && |rx_samp_reg;
               rx_state_reg <= maj ? RX_IDLE : RX_BITS;
            end
            RX_BITS: if (tick_reg && rx_sub_reg == `SUB_LAST) begin
               rx_idx_reg <= rx_idx_reg + 1'b1;
               if (!(&rx_samp_reg) && |rx_samp_reg)
                  rx_noise_reg <= 1'b1;
               if (rx_idx_reg < data_bits) begin
                  rx_shift_reg <= nine ? {maj, rx_shift_reg[8:1]}
                     : {1'b0, maj, rx_shift_reg[7:1]};
                  rx_par_reg   <= rx_par_reg ^ maj;
               end else if (par_en && rx_idx_reg == data_bits) begin
                  rx_parity_error_flag_reg <= rx_par_reg ^ maj;
               end else begin
                  rx_framing_error_flag_reg  <= !maj;
                  rx_done_reg  <= 1'b1;
                  rx_state_reg <= RX_IDLE;
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
      end
   end

   assign rx_word = '{ninth: nine & rx_shift_reg[8],
                      data: rx_shift_reg[7:0]};

   rx_fifo #(
      .WIDTH ($bits(rx_word_t)),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .flush_in      (!mod_en),
      .in_valid_in   (rx_done_reg && !overrun_flag_reg),
      .in_data_in    (rx_word),
      .in_ready_out  (fifo_in_ready),
      .out_valid_out (fifo_valid),
      .out_data_out  (fifo_head),
      .out_ready_in  (rd_data)
   );

   // Error flags: a new event in the clearing cycle still sets.
   always_ff @(posedge clk_in) begin
      if (rst_in || !mod_en) begin
         parity_error_flag_reg <= 1'b0;
         nf_reg   <= 1'b0;
         framing_error_flag_reg <= 1'b0;
         overrun_flag_reg <= 1'b0;
      end else begin
         if (err_clear) begin
            parity_error_flag_reg <= 1'b0;
            nf_reg   <= 1'b0;
            framing_error_flag_reg <= 1'b0;
            overrun_flag_reg <= 1'b0;
         end
         if (rx_done_reg && (!fifo_in_ready || overrun_flag_reg))
            overrun_flag_reg <= 1'b1;
         else if (rx_done_reg) begin
            parity_error_flag_reg <= par_en && rx_parity_error_flag_reg;
            nf_reg   <= rx_noise_reg;
            framing_error_flag_reg <= rx_framing_error_flag_reg;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in || !mod_en)
         status_seen_reg <= 1'b0;
      else if (rd_status)
         status_seen_reg <= 1'b1;
      else if (wr_data || rd_data)
         status_seen_reg <= 1'b0;
   end

   // Pin ownership; the LCD driver wins whenever it is on.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         tx_pin_oe_out     <= 1'b0;
         rx_pin_owned_out  <= 1'b0;
         rx_pullup_off_out <= 1'b0;
      end else begin
         tx_pin_oe_out     <= tx_on && pins_free;
         rx_pin_owned_out  <= rx_on && pins_free;
         rx_pullup_off_out <= rx_on && pins_free;
      end
   end

   // Interrupt sources, one level per event.
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         irq_tx_empty_out <= 1'b0;
         irq_tx_idle_out  <= 1'b0;
         irq_receive_out  <= 1'b0;
         irq_overrun_out  <= 1'b0;
         irq_address_out  <= 1'b0;
         irq_wake_out     <= 1'b0;
      end else begin
         irq_tx_empty_out <= ctrl_b_reg[`CB_EMPTY_IRQ_EN] && transmit_register_empty_reg;
         irq_tx_idle_out  <= ctrl_b_reg[`CB_IDLE_IRQ_EN] && transmitter_idle_flag_reg;
         irq_receive_out  <= ctrl_b_reg[`CB_RX_IRQ_EN] && fifo_valid &&
            (!ctrl_b_reg[`CB_ADDR_DETECT] || head_msb);
         irq_overrun_out  <= ctrl_b_reg[`CB_RX_IRQ_EN] && overrun_flag_reg;
         irq_address_out  <= ctrl_b_reg[`CB_RX_IRQ_EN] && fifo_valid &&
            ctrl_b_reg[`CB_ADDR_DETECT] && head_msb;
         irq_wake_out     <= ctrl_b_reg[`CB_WAKE_EN] && pins_free &&
            !rx_sync_reg[2] && !rx_sync_reg[1];
      end
   end

   a_tx_idle_high: assert property (@(posedge clk_in)
      disable iff (rst_in)
      tx_state_reg == TX_IDLE && !$past(tx_load) |-> tx_pin_out)
      else $error("transmit line low while idle");
   a_start_bit_low: assert property (@(posedge clk_in)
      disable iff (rst_in)
      tx_load |=> !tx_pin_out && tx_state_reg == TX_SHIFT)
      else $error("frame did not open with a low start bit");
   a_load_sets_empty: assert property (@(posedge clk_in)
      disable iff (rst_in)
      tx_load && !transmit_register_empty_reg && mod_en |=> transmit_register_empty_reg)
      else $error("holding register not empty after load");
   a_disable_resets: assert property (@(posedge clk_in)
      disable iff (rst_in)
      !mod_en |=> transmit_register_empty_reg && transmitter_idle_flag_reg && !overrun_flag_reg && !fifo_valid)
      else $error("disable left datapath state behind");
   a_overrun_sets: assert property (@(posedge clk_in)
      disable iff (rst_in)
      rx_done_reg && !fifo_in_ready && mod_en |=> overrun_flag_reg)
      else $error("full queue did not raise overrun");
   a_tx_pin_release: assert property (@(posedge clk_in)
      disable iff (rst_in)
      !ctrl_b_reg[`CB_TX_ON] |=> !tx_pin_oe_out)
      else $error("transmit pin held while transmitter off");
   a_lcd_priority: assert property (@(posedge clk_in)
      disable iff (rst_in)
      lcd_active_in |=> !tx_pin_oe_out && !rx_pin_owned_out)
      else $error("pins taken while LCD driver active");
   a_error_clear: assert property (@(posedge clk_in)
      disable iff (rst_in)
      err_clear && !rx_done_reg |=> !parity_error_flag_reg && !framing_error_flag_reg && !nf_reg)
      else $error("error flags survived the clearing sequence");
endmodule

/* verif/serial_partner.sv */
// Far-end serial device model: sends frames and captures frames.
module serial_partner #(
   parameter int BIT = 16
) (
   input  wire logic clk_in,
   input  wire logic tx_line_in,
   output logic      rx_line_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got;
   logic       stop_ok;
   initial rx_line_out = 1'b1;
   // Eight data bits, one stop bit, optional even parity or a wrong one.
   task automatic send(input logic [7:0] d, input logic par, input logic bad);
      logic [10:0] f;
      int          n;
      f = par ? {1'b1, ^d ^ bad, d, 1'b0} : {2'b11, d, 1'b0};
      n = par ? 11 : 10;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_in);
         rx_line_out = f[i];
         repeat (BIT - 1) @(negedge clk_in);
      end
   endtask
   // Capture at bit centres, timed from the falling edge of the start bit.
   initial begin
      forever begin
         @(negedge tx_line_in);
         repeat (BIT + BIT / 2) @(negedge clk_in);
         for (int i = 0; i < 8; i++) begin
            got[i] = tx_line_in;
            repeat (BIT) @(negedge clk_in);
         end
         stop_ok = tx_line_in;
      end
   end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the serial transceiver.
`include "uart_defines.svh"
module tb_top
   import uart_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int BIT = 16;
   typedef struct {
      logic [2:0] a;
      logic [7:0] w;
      logic [7:0] r;
   } row_t;
   logic       clk_in;
   logic       rst_in;
   reg_req_t   req;
   logic [7:0] rdata;
   logic       rx_line;
   logic       lcd;
   logic       tx_pin;
   logic       tx_oe;
   logic       rx_owned;
   logic       pu_off;
   logic       irq_rx;
   logic       irq_empty;
   logic       irq_idle;
   logic       irq_ovr;
   logic       irq_addr;
   logic       irq_wake;
   int         err_count;
   int         checks;
   row_t       rows [5] = '{'{`ADDR_CTRL_B, 8'h3F, 8'h3F},
      '{`ADDR_BAUD, 8'hA7, 8'hA7}, '{`ADDR_CTRL_A, 8'h7C, 8'h78},
      '{3'h5, 8'h55, 8'h00}, '{`ADDR_STATUS, 8'hFF, 8'h0B}};
   // The transmit line has a pull-up, so a released pin reads high.
   wire        tx_wire = tx_oe ? tx_pin : 1'b1;
   async_serial_transceiver #(.RX_DEPTH(2)) uut (
      .clk_in            (clk_in),
      .reg_req_in        (req),
      .rst_in            (rst_in),
      .reg_rdata_out     (rdata),
      .rx_pin_in         (rx_line),
      .lcd_active_in     (lcd),
      .tx_pin_out        (tx_pin),
      .tx_pin_oe_out     (tx_oe),
      .rx_pin_owned_out  (rx_owned),
      .rx_pullup_off_out (pu_off),
      .irq_tx_empty_out  (irq_empty),
      .irq_tx_idle_out   (irq_idle),
      .irq_receive_out   (irq_rx),
      .irq_overrun_out   (irq_ovr),
      .irq_address_out   (irq_addr),
      .irq_wake_out      (irq_wake)
   );
   serial_partner #(.BIT(BIT)) far (
      .clk_in      (clk_in),
      .tx_line_in  (tx_wire),
      .rx_line_out (rx_line)
   );
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk_in);
      req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clk_in);
      req = '0;
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
      @(negedge clk_in);
      req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clk_in);
      req = '0;
      @(negedge clk_in);
      chk8(rdata, exp);
   endtask
   task automatic wait_bits(input int n);
      repeat (n * BIT) @(negedge clk_in);
   endtask
   task automatic final_report;
      $display("Counts: %0d checks, %0d mismatches", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   // Whole run needs about two thousand cycles; this leaves a wide margin.
   initial begin
      repeat (50000) @(posedge clk_in);
      err_count++;
      final_report();
   end
   initial begin
      req = '0;
      lcd = 1'b0;
      rst_in = 1'b1;
      err_count = 0;
      checks = 0;
      repeat (3) @(negedge clk_in);
      rst_in = 1'b0;
      rdc(`ADDR_STATUS, 8'h0B);
      chk1(tx_pin, 1'b1);
      chk1(tx_oe, 1'b0);
      $display("Test reset done");
      foreach (rows[i]) begin
         reg_wr(rows[i].a, rows[i].w);
         rdc(rows[i].a, rows[i].r);
      end
      chk1(irq_empty & irq_idle, 1'b1);
      chk1(irq_wake, 1'b0);
      fork
         far.send(8'hFE, 1'b0, 1'b0);
         begin
            repeat (8) @(negedge clk_in);
            chk1(irq_wake, 1'b1);
         end
      join
      $display("Test register table done");
      reg_wr(`ADDR_BAUD, 8'h00);
      reg_wr(`ADDR_CTRL_A, 8'h80);
      reg_wr(`ADDR_CTRL_B, 8'hE4);
      repeat (2) @(negedge clk_in);
      chk1(tx_oe, 1'b1);
      chk1(rx_owned & pu_off, 1'b1);
      fork
         reg_wr(`ADDR_DATA, 8'hA5);
         far.send(8'h3C, 1'b0, 1'b0);
      join
      wait_bits(3);
      chk8(far.got, 8'hA5);
      chk1(far.stop_ok, 1'b1);
      chk1(irq_rx, 1'b1);
      chk1(irq_empty | irq_idle, 1'b0);
      rdc(`ADDR_DATA, 8'h3C);
      rdc(`ADDR_STATUS, 8'h0B);
      $display("Test full duplex done");
      far.send(8'h11, 1'b0, 1'b0);
      far.send(8'h22, 1'b0, 1'b0);
      far.send(8'h33, 1'b0, 1'b0);
      wait_bits(1);
      rdc(`ADDR_STATUS, 8'h1F);
      chk1(irq_ovr, 1'b1);
      rdc(`ADDR_DATA, 8'h11);
      rdc(`ADDR_STATUS, 8'h0F);
      rdc(`ADDR_DATA, 8'h22);
      rdc(`ADDR_STATUS, 8'h0B);
      $display("Test overrun done");
      reg_wr(`ADDR_CTRL_A, 8'hA0);
      far.send(8'h5A, 1'b1, 1'b1);
      wait_bits(1);
      rdc(`ADDR_STATUS, 8'h8F);
      rdc(`ADDR_DATA, 8'h5A);
      far.send(8'h5A, 1'b1, 1'b0);
      wait_bits(1);
      rdc(`ADDR_STATUS, 8'h0F);
      rdc(`ADDR_DATA, 8'h5A);
      reg_wr(`ADDR_CTRL_B, 8'hF4);
      far.send(8'h12, 1'b1, 1'b0);
      wait_bits(1);
      chk1(irq_rx, 1'b0);
      chk1(irq_addr, 1'b0);
      rdc(`ADDR_DATA, 8'h12);
      far.send(8'h92, 1'b1, 1'b0);
      wait_bits(1);
      chk1(irq_rx, 1'b1);
      chk1(irq_addr, 1'b1);
      rdc(`ADDR_DATA, 8'h92);
      reg_wr(`ADDR_CTRL_A, 8'hB0);
      far.send(8'h5A, 1'b1, 1'b1);
      wait_bits(1);
      rdc(`ADDR_STATUS, 8'h0F);
      rdc(`ADDR_DATA, 8'h5A);
      $display("Test parity and address done");
      lcd = 1'b1;
      repeat (2) @(negedge clk_in);
      chk1(tx_oe | rx_owned, 1'b0);
      lcd = 1'b0;
      reg_wr(`ADDR_DATA, 8'hC3);
      wait_bits(2);
      reg_wr(`ADDR_CTRL_A, 8'h20);
      repeat (3) @(negedge clk_in);
      rdc(`ADDR_STATUS, 8'h0B);
      rdc(`ADDR_CTRL_B, 8'h34);
      chk1(tx_oe | rx_owned, 1'b0);
      chk1(tx_pin, 1'b1);
      $display("Test disable done");
      final_report();
   end
endmodule
